// ---- design/ecp_pkg.sv ----
// Shared constants for the extended-capabilities parallel port.
package ecp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_DATA = 16'h0000;
  localparam logic [15:0] OFS_STAT = 16'h0001;
  localparam logic [15:0] OFS_CTRL = 16'h0002;
  localparam logic [15:0] OFS_FIFO = 16'h0400;
  localparam logic [15:0] OFS_CFGB = 16'h0401;
  localparam logic [15:0] OFS_ECR  = 16'h0402;

  // ----------------------------------------------------------------
  // Modes, fields and fixed values
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_STD  = 3'h0;
  localparam logic [2:0] MODE_BIDI = 3'h1;
  localparam logic [2:0] MODE_CMPF = 3'h2;
  localparam logic [2:0] MODE_ECP  = 3'h3;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG  = 3'h7;
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT   = 2;
  localparam int CTL_SELIN  = 3;
  localparam int CTL_ACKIE  = 4;
  localparam int CTL_DIR    = 5;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [2:0] ECR_MODE_RESET = 3'h0;
  localparam logic [2:0] ECR_LOW_RESET  = 3'h0;
  localparam logic [7:0] CAPA_VALUE = 8'h10;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // Handshake timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 200;
  localparam int SETUP_NS    = 500;
  localparam int STROBE_NS   = 500;
  localparam int SETUP_CYC   = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC  = (STROBE_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Handshake states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    HS_IDLE   = 6'b000001,
    HS_SETUP  = 6'b000010,
    HS_STROBE = 6'b000100,
    HS_HOLD   = 6'b001000,
    HS_REV    = 6'b010000,
    HS_REVACK = 6'b100000
  } ecp_hs_t;

endpackage : ecp_pkg

// ---- design/ecp_port.sv ----
// Parallel port register set, shared FIFO and automatic handshakes.
// How it works
// R1 - Offsets 000h, 001h, 002h, 400h, 401h, 402h decode differently per mode.
// R2 - Mode field: standard, bidirectional, compat FIFO, ECP, EPP, reserved, test, config.
// R3 - Offsets are relative to the port base; access only when address enable permits.
// R4 - Modes 000/001: data register resets, latches on write strobe rise, drives lines.
// R5 - Data offset reads in modes 000/001 return live port data line levels.
// R6 - Mode 011 writes to 000h enter FIFO tagged as address, forward only.
// R7 - Status bits 0 to 2 read as zero.
// R8 - Status bits 3 to 6 read fault, select, paper error and acknowledge inputs.
// R9 - Status bit 7 reads the inverse of busy.
// R10 - Control bits 0 to 5 reset to zero; bits 6 and 7 read low.
// R11 - Control bits drive strobe, autofeed, select-in inverted; initialize not inverted.
// R12 - With control bit 4 set, acknowledge rising edge raises an interrupt request.
// R13 - Direction bit ignored in modes 000 and 010; elsewhere 1 means receive.
// R14 - Mode 010 sends FIFO bytes with the compatibility handshake, forward only.
// R15 - Mode 011 forward sends FIFO data bytes with the extended handshake.
// R16 - Mode 011 reverse receives peripheral bytes into FIFO; host reads them.
// R17 - Test mode FIFO is read and written by host, never runs the handshake.
// R18 - Test FIFO write when full is discarded without stalling.
// R19 - Test FIFO read when empty returns the last read byte again.
// R20 - Full and empty always show true occupancy; test FIFO runs at bus rate.
// R21 - Test FIFO reads come from the head in first-in first-out order.
// R22 - Mode 111 read of 400h returns 10h; writes ignored.
// R23 - Shared transfer FIFO holds 16 bytes for both directions.
// R24 - Forward ECP address and data bytes share one FIFO in written order.
// R25 - Full reads 1 when no room; empty reads 1 only when no bytes held.
// R26 - Each FIFO entry carries a tag bit telling address from data.
`timescale 1ns/100ps

module ecp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i,
  // Occupancy
  output logic                  full_o,
  output logic                  empty_o
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign full_o      = (count_reg == (AW+1)'(DEPTH)); // see R25
  assign empty_o     = (count_reg == '0); // see R25
  assign in_ready_o  = !full_o;
  assign out_valid_o = !empty_o;
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && !full_o; // see R18
  assign pop         = out_ready_i && !empty_o;

  always_ff @(posedge clk_i)
  begin
    if (ce_i && push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else if (ce_i)
    begin
      if (flush_i)
      begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg  <= '0;
      end
      else
      begin
        if (push)
        begin
          wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop)
        begin
          rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1; // see R21
        end
        if (push && !pop)
        begin
          count_reg <= count_reg + 1'b1;
        end
        else if (pop && !push)
        begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end

endmodule : ecp_fifo

module ecp_port #(
  parameter int FIFO_DEPTH = 16,
  parameter int FIFO_AW    = 4
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Host bus
  input  wire logic [15:0] port_base_i,
  input  wire logic [15:0] host_addr_i,
  input  wire logic        address_enable_qualifier_i,
  input  wire logic        host_write_strobe_n_i,
  input  wire logic        host_read_strobe_n_i,
  input  wire logic [7:0]  host_wdata_i,
  output logic      [7:0]  host_rdata_o,
  output logic             host_irq_o,
  // Peripheral data lines
  input  wire logic [7:0]  port_data_lines_i,
  output logic      [7:0]  port_data_lines_o,
  output logic             port_data_lines_oe_n_o,
  // Peripheral status inputs
  input  wire logic        peripheral_fault_n_i,
  input  wire logic        select_i,
  input  wire logic        paper_error_i,
  input  wire logic        peripheral_ack_n_i,
  input  wire logic        busy_i,
  // Peripheral control outputs
  output logic             data_strobe_n_o,
  output logic             auto_linefeed_n_o,
  output logic             initialize_n_o,
  output logic             select_in_n_o
);

  // ----------------------------------------------------------------
  // Decode and strobe edges
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [15:0] ofs, input logic [15:0] want);
    hit = !address_enable_qualifier_i && (ofs == want); // see R3
  endfunction : hit

  logic [15:0]    ofs;
  logic           wr_n_q_reg;
  logic           rd_n_q_reg;
  logic           ack_n_q_reg;
  logic           wr_rise;
  logic           rd_rise;
  logic [7:0]     data_reg;
  logic [5:0]     ctrl_reg;
  logic [2:0]     mode_reg;
  logic [2:0]     ecr_low_reg;
  logic [7:0]     last_read_reg;
  logic           dir_in;
  logic           fifo_mode;
  logic           auto_mode;
  logic           host_push;
  logic           host_tag;
  logic           host_pop;
  logic           hs_pop;
  logic           hs_push;
  logic           f_in_valid;
  logic [8:0]     f_in_data;
  logic           f_in_ready;
  logic           f_out_valid;
  logic [8:0]     f_out_data;
  logic           f_full;
  logic           f_empty;
  logic           flush;
  logic [7:0]     status_val;
  logic [7:0]     rdata_next;
  ecp_pkg::ecp_hs_t hs_state_reg;
  logic [7:0]     hs_cnt_reg;
  logic [7:0]     hs_data_reg;
  logic           hs_tag_reg;
  logic           hs_strobe_n_reg;
  logic           hs_hostack_reg;

  assign ofs     = host_addr_i - port_base_i; // see R3
  assign wr_rise = !wr_n_q_reg && host_write_strobe_n_i;
  assign rd_rise = !rd_n_q_reg && host_read_strobe_n_i;
  assign dir_in  = ctrl_reg[ecp_pkg::CTL_DIR] && (mode_reg != ecp_pkg::MODE_STD)
                   && (mode_reg != ecp_pkg::MODE_CMPF); // see R13
  assign auto_mode = (mode_reg == ecp_pkg::MODE_CMPF) || (mode_reg == ecp_pkg::MODE_ECP);
  assign fifo_mode = auto_mode || (mode_reg == ecp_pkg::MODE_TEST);
  assign flush   = !fifo_mode && (mode_reg != ecp_pkg::MODE_CFG);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_n_q_reg  <= 1'b1;
      rd_n_q_reg  <= 1'b1;
      ack_n_q_reg <= 1'b1;
    end
    else if (ce_i)
    begin
      wr_n_q_reg  <= host_write_strobe_n_i;
      rd_n_q_reg  <= host_read_strobe_n_i;
      ack_n_q_reg <= peripheral_ack_n_i;
    end
  end

  // ----------------------------------------------------------------
  // Host writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_reg <= ecp_pkg::DATA_RESET; // see R4
    end
    else if (ce_i && wr_rise && hit(ofs, ecp_pkg::OFS_DATA)
             && (mode_reg == ecp_pkg::MODE_STD || mode_reg == ecp_pkg::MODE_BIDI))
    begin
      data_reg <= host_wdata_i; // see R4
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= ecp_pkg::CTRL_RESET; // see R10
    end
    else if (ce_i && wr_rise && hit(ofs, ecp_pkg::OFS_CTRL))
    begin
      ctrl_reg <= host_wdata_i[5:0]; // see R10
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_reg    <= ecp_pkg::ECR_MODE_RESET;
      ecr_low_reg <= ecp_pkg::ECR_LOW_RESET;
    end
    else if (ce_i && wr_rise && hit(ofs, ecp_pkg::OFS_ECR))
    begin
      mode_reg    <= host_wdata_i[7:5]; // see R2
      ecr_low_reg <= host_wdata_i[4:2];
    end
  end

  // Host FIFO pushes: address tag at 000h in mode 011, data at 400h.
  always_comb
  begin
    host_push = 1'b0;
    host_tag  = 1'b0;
    if (wr_rise && hit(ofs, ecp_pkg::OFS_DATA) && mode_reg == ecp_pkg::MODE_ECP && !dir_in)
    begin
      host_push = 1'b1; // see R6
      host_tag  = 1'b1; // see R26
    end
    else if (wr_rise && hit(ofs, ecp_pkg::OFS_FIFO))
    begin
      host_push = fifo_mode && !(mode_reg == ecp_pkg::MODE_ECP && dir_in); // see R14 see R15 see R17
    end
  end

  assign host_pop   = rd_rise && hit(ofs, ecp_pkg::OFS_FIFO)
                      && ((mode_reg == ecp_pkg::MODE_TEST)
                      || (mode_reg == ecp_pkg::MODE_ECP && dir_in)); // see R16 see R17
  assign f_in_valid = host_push || hs_push; // see R24
  assign f_in_data  = hs_push ? {1'b0, port_data_lines_i} : {host_tag, host_wdata_i};

  ecp_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .flush_i     (flush),
    .in_valid_i  (f_in_valid),
    .in_data_i   (f_in_data),
    .in_ready_o  (f_in_ready),
    .out_valid_o (f_out_valid),
    .out_data_o  (f_out_data),
    .out_ready_i (host_pop || hs_pop),
    .full_o      (f_full),
    .empty_o     (f_empty)
  ); // see R23

  // ----------------------------------------------------------------
  // Host reads
  // ----------------------------------------------------------------
  assign status_val = {!busy_i, peripheral_ack_n_i, paper_error_i, select_i,
                       peripheral_fault_n_i, 3'h0}; // see R7 see R8 see R9

  always_comb
  begin
    rdata_next = ecp_pkg::UNMAPPED_VALUE;
    if (hit(ofs, ecp_pkg::OFS_DATA))
    begin
      rdata_next = port_data_lines_i; // see R5
    end
    else if (hit(ofs, ecp_pkg::OFS_STAT))
    begin
      rdata_next = status_val;
    end
    else if (hit(ofs, ecp_pkg::OFS_CTRL))
    begin
      rdata_next = {2'h0, ctrl_reg}; // see R10
    end
    else if (hit(ofs, ecp_pkg::OFS_FIFO) && mode_reg == ecp_pkg::MODE_CFG)
    begin
      rdata_next = ecp_pkg::CAPA_VALUE; // see R22
    end
    else if (hit(ofs, ecp_pkg::OFS_FIFO) && fifo_mode)
    begin
      rdata_next = f_empty ? last_read_reg : f_out_data[7:0]; // see R19 see R21
    end
    else if (hit(ofs, ecp_pkg::OFS_CFGB) && mode_reg == ecp_pkg::MODE_CFG)
    begin
      rdata_next = {1'b0, host_irq_o, 6'h00};
    end
    else if (hit(ofs, ecp_pkg::OFS_ECR))
    begin
      rdata_next = {mode_reg, ecr_low_reg, f_full, f_empty}; // see R20 see R25
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      host_rdata_o  <= 8'h00;
      last_read_reg <= 8'h00;
    end
    else if (ce_i)
    begin
      host_rdata_o <= host_read_strobe_n_i ? 8'h00 : rdata_next; // see R1
      if (host_pop && !f_empty)
      begin
        last_read_reg <= f_out_data[7:0]; // see R19
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      host_irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      host_irq_o <= ctrl_reg[ecp_pkg::CTL_ACKIE] && !ack_n_q_reg && peripheral_ack_n_i; // see R12
    end
  end

  // ----------------------------------------------------------------
  // Automatic handshake
  // ----------------------------------------------------------------
  assign hs_pop  = (hs_state_reg == ecp_pkg::HS_IDLE) && f_out_valid && !busy_i && !dir_in
                   && auto_mode; // see R14 see R15
  assign hs_push = (hs_state_reg == ecp_pkg::HS_REV) && !peripheral_ack_n_i && f_in_ready; // see R16

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hs_state_reg    <= ecp_pkg::HS_IDLE;
      hs_cnt_reg      <= 8'h00;
      hs_data_reg     <= 8'h00;
      hs_tag_reg      <= 1'b0;
      hs_strobe_n_reg <= 1'b1;
      hs_hostack_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!auto_mode)
      begin
        hs_state_reg    <= ecp_pkg::HS_IDLE; // see R17
        hs_strobe_n_reg <= 1'b1;
        hs_hostack_reg  <= 1'b0;
      end
      else
      begin
        case (hs_state_reg)
          ecp_pkg::HS_IDLE:
          begin
            hs_cnt_reg <= 8'h00;
            if (hs_pop)
            begin
              hs_data_reg  <= f_out_data[7:0];
              hs_tag_reg   <= f_out_data[8]; // see R26
              hs_state_reg <= ecp_pkg::HS_SETUP;
            end
            else if (dir_in && mode_reg == ecp_pkg::MODE_ECP)
            begin
              hs_state_reg <= ecp_pkg::HS_REV;
            end
          end
          ecp_pkg::HS_SETUP:
          begin
            hs_cnt_reg <= hs_cnt_reg + 8'h01;
            if (hs_cnt_reg == 8'(ecp_pkg::SETUP_CYC - 1))
            begin
              hs_cnt_reg      <= 8'h00;
              hs_strobe_n_reg <= 1'b0;
              hs_state_reg    <= ecp_pkg::HS_STROBE;
            end
          end
          ecp_pkg::HS_STROBE:
          begin
            hs_cnt_reg <= hs_cnt_reg + 8'h01;
            if ((mode_reg == ecp_pkg::MODE_ECP && busy_i)
                || (mode_reg == ecp_pkg::MODE_CMPF && hs_cnt_reg == 8'(ecp_pkg::STROBE_CYC - 1)))
            begin
              hs_strobe_n_reg <= 1'b1;
              hs_state_reg    <= ecp_pkg::HS_HOLD;
            end
          end
          ecp_pkg::HS_HOLD:
          begin
            if (!busy_i || mode_reg == ecp_pkg::MODE_CMPF)
            begin
              hs_state_reg <= ecp_pkg::HS_IDLE;
            end
          end
          ecp_pkg::HS_REV:
          begin
            if (!dir_in)
            begin
              hs_state_reg <= ecp_pkg::HS_IDLE;
            end
            else if (hs_push)
            begin
              hs_hostack_reg <= 1'b1;
              hs_state_reg   <= ecp_pkg::HS_REVACK;
            end
          end
          ecp_pkg::HS_REVACK:
          begin
            if (peripheral_ack_n_i)
            begin
              hs_hostack_reg <= 1'b0;
              hs_state_reg   <= ecp_pkg::HS_IDLE;
            end
          end
          default:
          begin
            hs_state_reg <= ecp_pkg::HS_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      port_data_lines_o      <= 8'h00;
      port_data_lines_oe_n_o <= 1'b0;
      data_strobe_n_o        <= 1'b1;
      auto_linefeed_n_o      <= 1'b1;
      initialize_n_o         <= 1'b0;
      select_in_n_o          <= 1'b1;
    end
    else if (ce_i)
    begin
      port_data_lines_oe_n_o <= dir_in; // see R13
      if (mode_reg == ecp_pkg::MODE_TEST)
      begin
        port_data_lines_o <= f_out_data[7:0]; // see R17
      end
      else if (auto_mode)
      begin
        port_data_lines_o <= hs_data_reg;
      end
      else
      begin
        port_data_lines_o <= data_reg; // see R4
      end
      if (auto_mode)
      begin
        data_strobe_n_o <= hs_strobe_n_reg; // see R14 see R15
        if (mode_reg == ecp_pkg::MODE_ECP)
        begin
          auto_linefeed_n_o <= dir_in ? hs_hostack_reg : !hs_tag_reg; // see R15 see R16
        end
        else
        begin
          auto_linefeed_n_o <= !ctrl_reg[ecp_pkg::CTL_AUTOFD];
        end
      end
      else
      begin
        data_strobe_n_o   <= !ctrl_reg[ecp_pkg::CTL_STROBE]; // see R11
        auto_linefeed_n_o <= !ctrl_reg[ecp_pkg::CTL_AUTOFD]; // see R11
      end
      initialize_n_o <= ctrl_reg[ecp_pkg::CTL_INIT]; // see R11
      select_in_n_o  <= !ctrl_reg[ecp_pkg::CTL_SELIN]; // see R11
    end
  end

endmodule : ecp_port

// ---- dv/ecp_chk.sv ----
// Concurrent checks on the host bus and the peripheral pins of the parallel port.
`timescale 1ns/100ps
module ecp_chk (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Host bus
  input wire logic [15:0] port_base_i,
  input wire logic [15:0] host_addr_i,
  input wire logic        address_enable_qualifier_i,
  input wire logic        host_write_strobe_n_i,
  input wire logic        host_read_strobe_n_i,
  input wire logic [7:0]  host_wdata_i,
  input wire logic [7:0]  host_rdata_o,
  input wire logic        host_irq_o,
  // Peripheral side
  input wire logic [7:0]  port_data_lines_o,
  input wire logic        port_data_lines_oe_n_o,
  input wire logic        peripheral_fault_n_i,
  input wire logic        select_i,
  input wire logic        paper_error_i,
  input wire logic        peripheral_ack_n_i,
  input wire logic        busy_i,
  input wire logic        data_strobe_n_o,
  input wire logic        auto_linefeed_n_o,
  input wire logic        initialize_n_o,
  input wire logic        select_in_n_o
);
  logic       wr_prev;
  logic [2:0] mode_q;
  logic [7:0] ctl_q;
  logic [7:0] dat_q;
  wire [15:0] ofs = host_addr_i - port_base_i;
  wire wr_tk = host_write_strobe_n_i & ~wr_prev & ~address_enable_qualifier_i;
  wire rd_ok = ~host_read_strobe_n_i & ~address_enable_qualifier_i;
  wire [7:0] stat = {~busy_i, peripheral_ack_n_i, paper_error_i, select_i, peripheral_fault_n_i, 3'h0};
  wire [3:0] pins = {data_strobe_n_o, auto_linefeed_n_o, initialize_n_o, select_in_n_o};

  // Shadow of the mode, control and data writes.
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) {wr_prev, mode_q, ctl_q, dat_q} <= 20'h80000;
    else
    begin
      wr_prev <= host_write_strobe_n_i;
      if (wr_tk && ofs == ecp_pkg::OFS_ECR) mode_q <= host_wdata_i[7:5];
      if (wr_tk && ofs == ecp_pkg::OFS_CTRL) ctl_q <= host_wdata_i;
      if (wr_tk && ofs == ecp_pkg::OFS_DATA) dat_q <= host_wdata_i;
    end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr_ctl;
    wr_tk && ofs == ecp_pkg::OFS_CTRL && mode_q == ecp_pkg::MODE_STD;
  endsequence
  sequence s_ack_rise;
    $rose(peripheral_ack_n_i) && ctl_q[4];
  endsequence

  AST_STAT_READ: assert property (rd_ok && ofs == ecp_pkg::OFS_STAT |=> host_rdata_o == $past(stat))
    else $error("status read differs from pins");
  AST_CTRL_READ: assert property (rd_ok && ofs == ecp_pkg::OFS_CTRL |=> host_rdata_o == ($past(ctl_q) & 8'h3F))
    else $error("control read differs");
  AST_CTRL_PINS: assert property (s_wr_ctl |-> ##[1:2] pins == {~ctl_q[0], ~ctl_q[1], ctl_q[2], ~ctl_q[3]})
    else $error("control pins wrong");
  AST_DATA_DRIVE: assert property (wr_tk && ofs == 16'h0000 && mode_q == 3'h0 |-> ##[1:2] port_data_lines_o == dat_q)
    else $error("data lines wrong");
  AST_AEN_IGNORE: assert property (host_write_strobe_n_i && !wr_prev && address_enable_qualifier_i && mode_q == 3'h0
                                   |=> $stable(port_data_lines_o)[*3])
    else $error("guarded write changed data lines");
  AST_CFG_A: assert property (rd_ok && ofs == ecp_pkg::OFS_FIFO && mode_q == ecp_pkg::MODE_CFG |=> host_rdata_o == 8'h10)
    else $error("capability word wrong");
  AST_IRQ: assert property (s_ack_rise |-> ##[1:2] host_irq_o)
    else $error("no interrupt on acknowledge");
  AST_IRQ_PULSE: assert property (host_irq_o |=> !host_irq_o)
    else $error("interrupt longer than one cycle");
  AST_OE_STD: assert property ((mode_q == ecp_pkg::MODE_STD)[*3] |-> !port_data_lines_oe_n_o)
    else $error("data lines released in standard mode");
endmodule : ecp_chk

bind ecp_port ecp_chk i_chk (.*);

// ---- dv/ecp_periph.sv ----
// Behavioural printer model on the parallel pins.
`timescale 1ns/100ps
module ecp_periph (
  // Clock
  input  wire logic       clk_i,
  // Lines from the port
  input  wire logic       data_strobe_n_i,
  input  wire logic       auto_linefeed_n_i,
  input  wire logic [7:0] data_i,
  input  wire logic       oe_n_i,
  // Lines to the port
  output logic [7:0]      data_o,
  output logic            fault_n_o,
  output logic            select_o,
  output logic            paper_error_o,
  output logic            ack_n_o,
  output logic            busy_o
);
  int dly = 4;
  logic [8:0] got [$];
  // Released lines show the inverse of the last driven value.
  assign data_o = oe_n_i ? ~data_i : data_i;

  initial
  begin
    {fault_n_o, select_o, paper_error_o, ack_n_o, busy_o} = 5'b11010;
    forever
    begin
      @(negedge data_strobe_n_i);
      got.push_back({auto_linefeed_n_i, data_i});
      repeat (dly) @(posedge clk_i);
      busy_o <= 1'b1;
      @(posedge data_strobe_n_i);
      repeat (dly) @(posedge clk_i);
      busy_o <= 1'b0;
      ack_n_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      ack_n_o <= 1'b1;
    end
  end
endmodule : ecp_periph

// ---- dv/testbench.sv ----
// Self-checking bench for the parallel port register set.
`timescale 1ns/100ps
module testbench;
  localparam logic [15:0] BASE = 16'h0278;
  logic clk = 1'b0, rst = 1'b1, address_enable_qualifier = 1'b0, wr_n = 1'b1, rd_n = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, dlo, dli, d;
  logic irq, oe_n, strb, afd, init, slin, fault_n, sel, perr, ack_n, busy;
  logic [4:0] pat [2] = '{5'b10110, 5'b01001};
  logic [7:0] tv [3] = '{8'h44, 8'h33, 8'h22};
  int failures = 0, n_checks = 0, irq_cnt = 0;

  ecp_port i_dut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .port_base_i(BASE), .host_addr_i(addr),
    .address_enable_qualifier_i(address_enable_qualifier), .host_write_strobe_n_i(wr_n), .host_read_strobe_n_i(rd_n),
    .host_wdata_i(wdata), .host_rdata_o(rdata), .host_irq_o(irq), .port_data_lines_i(dli),
    .port_data_lines_o(dlo), .port_data_lines_oe_n_o(oe_n), .peripheral_fault_n_i(fault_n), .select_i(sel),
    .paper_error_i(perr), .peripheral_ack_n_i(ack_n), .busy_i(busy), .data_strobe_n_o(strb),
    .auto_linefeed_n_o(afd), .initialize_n_o(init), .select_in_n_o(slin));
  ecp_periph i_per (.clk_i(clk), .data_strobe_n_i(strb), .auto_linefeed_n_i(afd), .data_i(dlo), .oe_n_i(oe_n),
    .data_o(dli), .fault_n_o(fault_n), .select_o(sel), .paper_error_o(perr), .ack_n_o(ack_n), .busy_o(busy));

  initial
  begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (irq === 1'b1) irq_cnt++;

  task automatic wr(input logic [15:0] o, input logic [7:0] v);
    @(posedge clk);
    addr <= BASE + o;
    wdata <= v;
    wr_n <= 1'b0;
    @(posedge clk);
    wr_n <= 1'b1;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [15:0] o);
    @(posedge clk);
    addr <= BASE + o;
    rd_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 d = rdata;
    @(posedge clk);
    rd_n <= 1'b1;
  endtask : rd
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wait_got(input int n);
    for (int k = 0; k < 3000 && !(i_per.got.size() >= n && strb === 1'b1 && busy === 1'b0); k++) @(posedge clk);
  endtask : wait_got
  task automatic results;
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(16'h0000);
    cmp("data reset", 8'h00, d);
    rd(16'h0002);
    cmp("control reset", 8'h00, d);
    cmp("pins reset", 8'h0D, {4'h0, strb, afd, init, slin});
    wr(16'h0000, 8'hA5);
    rd(16'h0000);
    cmp("data read", 8'hA5, d);
    cmp("data lines", 8'hA5, dlo);
    address_enable_qualifier <= 1'b1;
    wr(16'h0000, 8'h5A);
    address_enable_qualifier <= 1'b0;
    rd(16'h0000);
    cmp("guarded data", 8'hA5, d);
    wr(16'h0002, 8'hEE);
    rd(16'h0002);
    cmp("control read", 8'h2E, d);
    cmp("pins set", 8'h0A, {4'h0, strb, afd, init, slin});
    cmp("drive enable", 8'h00, {7'h0, oe_n});
    wr(16'h0002, 8'h10);
    irq_cnt = 0;
    for (int i = 0; i < 2; i++)
    begin
      {i_per.busy_o, i_per.ack_n_o, i_per.paper_error_o, i_per.select_o, i_per.fault_n_o} <= pat[i];
      rd(16'h0001);
      cmp("status", {~pat[i][4], pat[i][3:0], 3'h0}, d);
    end
    {i_per.busy_o, i_per.select_o, i_per.fault_n_o} <= 3'b011;
    repeat (4) @(posedge clk);
    cmp("irq pulses", 8'h01, 8'(irq_cnt));
    wr(16'h0002, 8'h00);
    wr(16'h0402, 8'hE0);
    wr(16'h0400, 8'h55);
    rd(16'h0400);
    cmp("capability", 8'h10, d);
    wr(16'h0402, 8'h00);
    wr(16'h0402, 8'hC0);
    rd(16'h0402);
    cmp("ecr empty", 8'hC1, d);
    foreach (tv[i]) wr(16'h0400, tv[i]);
    foreach (tv[i])
    begin
      rd(16'h0400);
      cmp("test order", tv[i], d);
    end
    rd(16'h0400);
    cmp("underrun reread", 8'h22, d);
    rd(16'h0402);
    cmp("ecr drained", 8'hC1, d);
    for (int i = 1; i <= 17; i++) wr(16'h0400, 8'(i));
    rd(16'h0402);
    cmp("ecr full", 8'hC2, d);
    for (int i = 1; i <= 16; i++)
    begin
      rd(16'h0400);
      cmp("fill order", 8'(i), d);
    end
    rd(16'h0400);
    cmp("overrun dropped", 8'h10, d);
    cmp("no handshake", 8'h00, 8'(i_per.got.size()));
    wr(16'h0402, 8'h00);
    wr(16'h0402, 8'h40);
    wr(16'h0400, 8'h3C);
    wait_got(1);
    cmp("compat byte", 8'h3C, i_per.got[0][7:0]);
    i_per.dly = 40;
    wr(16'h0402, 8'h00);
    wr(16'h0402, 8'h60);
    wr(16'h0000, 8'hA1);
    wr(16'h0400, 8'hD2);
    wait_got(3);
    cmp("ecp first", 8'hA1, i_per.got[1][7:0]);
    cmp("ecp address tag", 8'h00, {7'h0, i_per.got[1][8]});
    cmp("ecp second", 8'hD2, i_per.got[2][7:0]);
    cmp("ecp data tag", 8'h01, {7'h0, i_per.got[2][8]});
    results();
  end
endmodule : testbench
